/* shared/tap_pkg.sv */
package tap_pkg;

  // ----------------------------------------
  // tap controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    st_reset   = 4'h0,
    st_idle    = 4'h1,
    st_sel_dr  = 4'h2,
    st_cap_dr  = 4'h3,
    st_shf_dr  = 4'h4,
    st_ex1_dr  = 4'h5,
    st_pau_dr  = 4'h6,
    st_ex2_dr  = 4'h7,
    st_upd_dr  = 4'h8,
    st_sel_ir  = 4'h9,
    st_cap_ir  = 4'ha,
    st_shf_ir  = 4'hb,
    st_ex1_ir  = 4'hc,
    st_pau_ir  = 4'hd,
    st_ex2_ir  = 4'he,
    st_upd_ir  = 4'hf
  } tap_state_e;

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  localparam int IR_LEN = 3;
  localparam logic [2:0] INSN_EXTEST = 3'h0;
  localparam logic [2:0] INSN_IDCODE = 3'h1;
  localparam logic [2:0] INSN_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSN_SAMPLE = 3'h4;
  localparam logic [2:0] INSN_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET = INSN_IDCODE;

  // ----------------------------------------
  // data registers and sampling
  // ----------------------------------------
  localparam int BSR_LEN = 109;
  localparam int ID_LEN = 32;
  // arbitrary identity value, names no real part
  localparam logic [31:0] ID_VALUE = 32'h0000_0001;
  localparam int SYNC_STAGES = 2;
  localparam int TMS_RESET_EDGES = 5;

endpackage : tap_pkg

/* shared/tap_ctrl_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tap_ctrl_if;
  logic tck_rise;
  logic tms;
  tap_pkg::tap_state_e state;

  modport ctrl (input tck_rise, input tms, output state);
  modport user (output tck_rise, output tms, input state);
endinterface : tap_ctrl_if
`default_nettype wire

/* src/tap_fsm.sv */
`timescale 1ns/1ns
`default_nettype none
module tap_fsm (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // controller link
  tap_ctrl_if.ctrl ctl
);

  tap_pkg::tap_state_e next_state;

  // ----------------------------------------
  // next state from tms at each test clock rise
  // ----------------------------------------
  // every state has a tms=1 path toward reset, so five highs always land there
  always_comb begin
    unique case (ctl.state)
      tap_pkg::st_reset: next_state = ctl.tms ? tap_pkg::st_reset : tap_pkg::st_idle;
      tap_pkg::st_idle: next_state = ctl.tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
      tap_pkg::st_sel_dr: next_state = ctl.tms ? tap_pkg::st_sel_ir : tap_pkg::st_cap_dr;
      tap_pkg::st_cap_dr: next_state = ctl.tms ? tap_pkg::st_ex1_dr : tap_pkg::st_shf_dr;
      tap_pkg::st_shf_dr: next_state = ctl.tms ? tap_pkg::st_ex1_dr : tap_pkg::st_shf_dr;
      tap_pkg::st_ex1_dr: next_state = ctl.tms ? tap_pkg::st_upd_dr : tap_pkg::st_pau_dr;
      tap_pkg::st_pau_dr: next_state = ctl.tms ? tap_pkg::st_ex2_dr : tap_pkg::st_pau_dr;
      tap_pkg::st_ex2_dr: next_state = ctl.tms ? tap_pkg::st_upd_dr : tap_pkg::st_shf_dr;
      tap_pkg::st_upd_dr: next_state = ctl.tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
      tap_pkg::st_sel_ir: next_state = ctl.tms ? tap_pkg::st_reset : tap_pkg::st_cap_ir;
      tap_pkg::st_cap_ir: next_state = ctl.tms ? tap_pkg::st_ex1_ir : tap_pkg::st_shf_ir;
      tap_pkg::st_shf_ir: next_state = ctl.tms ? tap_pkg::st_ex1_ir : tap_pkg::st_shf_ir;
      tap_pkg::st_ex1_ir: next_state = ctl.tms ? tap_pkg::st_upd_ir : tap_pkg::st_pau_ir;
      tap_pkg::st_pau_ir: next_state = ctl.tms ? tap_pkg::st_ex2_ir : tap_pkg::st_pau_ir;
      tap_pkg::st_ex2_ir: next_state = ctl.tms ? tap_pkg::st_upd_ir : tap_pkg::st_shf_ir;
      tap_pkg::st_upd_ir: next_state = ctl.tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl.state <= tap_pkg::st_reset;
    end else if (ctl.tck_rise) begin
      ctl.state <= next_state;
    end
  end

endmodule : tap_fsm
`default_nettype wire

/* src/sram_boundary_scan_tap.sv */
// Summary of operation
// - the tap controller moves state on each test clock rise as the mode select level dictates.
// - holding mode select high for five test clock rises reaches test-logic-reset from anywhere.
// - in scan mode the echo clocks follow the output clock pair, except under extest or sample-z.
// - with both output clocks high the echo clocks follow the input clock pair instead.
// - sample captures pin states at capture-dr and shifts the boundary chain in shift-dr.
// - instruction all ones puts the single bypass bit between data in and out in shift-dr.
`timescale 1ns/1ns
`default_nettype none
module sram_boundary_scan_tap #(
  parameter int BSR_LEN = tap_pkg::BSR_LEN
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // memory clock pins
  input wire logic clk_in_t,
  input wire logic clk_in_c,
  input wire logic clk_out_t,
  input wire logic clk_out_c,
  // echo clocks
  output logic echo_clock_true,
  output logic echo_clock_comp,
  // boundary cells
  input wire logic [BSR_LEN-1:0] pin_state,
  output logic [BSR_LEN-1:0] pin_drive,
  output logic extest_active
);

  tap_ctrl_if ctl ();

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic tck_d;
  logic [BSR_LEN-1:0] pins1;
  logic [BSR_LEN-1:0] pins2;
  logic tck_s;
  logic tdi_s;
  logic tck_fall;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      tck_d <= 1'b0;
    end else begin
      sync1 <= {clk_out_c, clk_out_t, clk_in_c, clk_in_t, tdi, tms, tck};
      sync2 <= sync1;
      tck_d <= sync2[0];
    end
  end

  // pins may be mid-transition when sampled; results then are not repeatable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pins1 <= '0;
      pins2 <= '0;
    end else begin
      pins1 <= pin_state;
      pins2 <= pins1;
    end
  end

  assign tck_s = sync2[0];
  assign tdi_s = sync2[2];
  assign ctl.tms = sync2[1];
  assign ctl.tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  tap_fsm u_fsm (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ctl(ctl)
  );

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  logic [tap_pkg::IR_LEN-1:0] ir_shift;
  logic [tap_pkg::IR_LEN-1:0] insn;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ir_shift <= tap_pkg::IR_CAPTURE;
    end else if (ctl.tck_rise) begin
      if (ctl.state == tap_pkg::st_cap_ir) begin
        ir_shift <= tap_pkg::IR_CAPTURE;
      end else if (ctl.state == tap_pkg::st_shf_ir) begin
        ir_shift <= {tdi_s, ir_shift[tap_pkg::IR_LEN-1:1]};
      end
    end
  end

  // update happens on the falling edge, as for any 1149.1 controller
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      insn <= tap_pkg::IR_RESET;
    end else if (ctl.state == tap_pkg::st_reset) begin
      insn <= tap_pkg::IR_RESET;
    end else if (tck_fall && ctl.state == tap_pkg::st_upd_ir) begin
      insn <= ir_shift;
    end
  end

  logic sel_bsr;
  logic sel_bypass;
  logic sel_id;
  logic scan_hiz;

  assign sel_id = (insn == tap_pkg::INSN_IDCODE);
  assign scan_hiz = (insn == tap_pkg::INSN_EXTEST) || (insn == tap_pkg::INSN_SAMPLE_Z);
  assign sel_bsr = scan_hiz || (insn == tap_pkg::INSN_SAMPLE);
  // reserved codes fall back to bypass so the chain length stays defined
  assign sel_bypass = !sel_bsr && !sel_id;

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  logic [BSR_LEN-1:0] bsr;
  logic [tap_pkg::ID_LEN-1:0] id_shift;
  logic bypass_bit;
  logic cap_dr;
  logic shf_dr;

  assign cap_dr = ctl.tck_rise && ctl.state == tap_pkg::st_cap_dr;
  assign shf_dr = ctl.tck_rise && ctl.state == tap_pkg::st_shf_dr;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bsr <= '0;
    end else if (sel_bsr) begin
      if (cap_dr) begin
        bsr <= pins2;
      end else if (shf_dr) begin
        bsr <= {tdi_s, bsr[BSR_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bypass_bit <= 1'b0;
    end else if (sel_bypass) begin
      if (cap_dr) begin
        bypass_bit <= 1'b0;
      end else if (shf_dr) begin
        bypass_bit <= tdi_s;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      id_shift <= '0;
    end else if (sel_id) begin
      if (cap_dr) begin
        id_shift <= tap_pkg::ID_VALUE;
      end else if (shf_dr) begin
        id_shift <= {tdi_s, id_shift[tap_pkg::ID_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_drive <= '0;
    end else if (tck_fall && sel_bsr && ctl.state == tap_pkg::st_upd_dr) begin
      pin_drive <= bsr;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      extest_active <= 1'b0;
    end else begin
      extest_active <= (insn == tap_pkg::INSN_EXTEST);
    end
  end

  // ----------------------------------------
  // serial output, changes on test clock fall
  // ----------------------------------------
  logic dr_bit;

  always_comb begin
    dr_bit = bypass_bit;
    if (sel_bsr) begin
      dr_bit = bsr[0];
    end else if (sel_id) begin
      dr_bit = id_shift[0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      if (ctl.state == tap_pkg::st_shf_ir) begin
        tdo <= ir_shift[0];
        tdo_oe_n <= 1'b0;
      end else if (ctl.state == tap_pkg::st_shf_dr) begin
        tdo <= dr_bit;
        tdo_oe_n <= 1'b0;
      end else begin
        tdo_oe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // echo clocks
  // ----------------------------------------
  // rebuilt from sampled pins, so only valid for slow scan-mode clocks
  logic out_tied_high;

  assign out_tied_high = sync2[5] & sync2[6];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      echo_clock_true <= 1'b0;
      echo_clock_comp <= 1'b0;
    end else if (scan_hiz) begin
      echo_clock_true <= 1'b0;
      echo_clock_comp <= 1'b0;
    end else if (out_tied_high) begin
      echo_clock_true <= sync2[3];
      echo_clock_comp <= sync2[4];
    end else begin
      echo_clock_true <= sync2[5];
      echo_clock_comp <= sync2[6];
    end
  end

endmodule : sram_boundary_scan_tap
`default_nettype wire

/* testbench/tap_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module tap_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  // memory and echo clocks
  input wire logic clk_in_t,
  input wire logic clk_in_c,
  input wire logic clk_out_t,
  input wire logic clk_out_c,
  input wire logic echo_clock_true,
  input wire logic echo_clock_comp,
  input wire logic extest_active
);
  logic tck_q;
  logic last_tms;
  logic [2:0] ones;
  wire logic tied = clk_out_t & clk_out_c;
  wire logic src_t = tied ? clk_in_t : clk_out_t;
  wire logic src_c = tied ? clk_in_c : clk_out_c;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // counted at the pin, two cycles ahead of what the design sees
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tck_q <= 1'b0;
      last_tms <= 1'b1;
      ones <= 3'h0;
    end else begin
      tck_q <= tck;
      if (tck && !tck_q) begin
        last_tms <= tms;
        ones <= !tms ? 3'h0 : (ones == 3'h7 ? ones : ones + 3'h1);
      end
    end
  end
  a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 3))
    else $error("tdo moved while test clock high");
  a_oe_on_fall: assert property ($changed(tdo_oe_n) |-> !$past(tck, 3))
    else $error("tdo enable moved while test clock high");
  a_shift_entry: assert property ($fell(tdo_oe_n) |-> !last_tms)
    else $error("shift entered with mode select high");
  a_shift_exit: assert property ($rose(tdo_oe_n) |-> last_tms)
    else $error("shift left with mode select low");
  a_tms_reset: assert property (ones >= 3'h5 |-> tdo_oe_n)
    else $error("still shifting after five mode select highs");
  a_extest_echo: assert property (extest_active |-> !echo_clock_true && !echo_clock_comp)
    else $error("echo clock running under extest");
  a_echo_true_src: assert property ($rose(echo_clock_true) |-> $past(src_t, 3))
    else $error("true echo rose without its source");
  a_echo_comp_src: assert property ($rose(echo_clock_comp) |-> $past(src_c, 3))
    else $error("complement echo rose without its source");
endmodule : tap_properties
bind sram_boundary_scan_tap tap_properties i_tap_properties (.clk_sys, .arst_n, .tck, .tms,
  .tdo, .tdo_oe_n, .clk_in_t, .clk_in_c, .clk_out_t, .clk_out_c, .echo_clock_true,
  .echo_clock_comp, .extest_active);
`default_nettype wire

/* testbench/tap_tester.sv */
`timescale 1ns/1ns
`default_nettype none
module tap_tester (
  // clock
  input wire logic clk_sys,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // test clock stands low between steps; tdo read at the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (10) @(posedge clk_sys);
    #1 tck = 1'b1;
    q = tdo;
    repeat (10) @(posedge clk_sys);
    #1 tck = 1'b0;
  endtask : step
  // data in toggles outside shifts so a stale level is never trusted
  task automatic move(input logic [7:0] path, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      step(path[i], ~tdi, q);
    end
  endtask : move
  task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    move(8'h01, 2);
  endtask : scan
  task automatic load_ir(input logic [2:0] code);
    logic [127:0] q;
    move(8'h03, 4);
    scan(3, 128'(code), q);
  endtask : load_ir
  task automatic dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    move(8'h01, 3);
    scan(n, din, dout);
  endtask : dr
endmodule : tap_tester
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic in_ph = 1'b0;
  logic out_ph = 1'b0;
  logic out_tie = 1'b0;
  logic [tap_pkg::BSR_LEN-1:0] pins = 109'h1_2345_6789_abcd_ef01_2345_6789;
  logic tck, tms, tdi, tdo, echo_t, echo_c, extest;
  logic tdo_oe_n;
  logic [tap_pkg::BSR_LEN-1:0] drive;
  int n_errors = 0;
  int n_compared = 0;
  // both pairs always complementary unless the output pair is tied high
  wire logic clk_out_t = out_tie | out_ph;
  wire logic clk_out_c = out_tie | ~out_ph;
  always #4 clk_sys = ~clk_sys;
  sram_boundary_scan_tap i_sram_boundary_scan_tap (.clk_sys, .arst_n, .tck, .tms, .tdi,
    .tdo, .tdo_oe_n, .clk_in_t(in_ph), .clk_in_c(~in_ph), .clk_out_t, .clk_out_c,
    .echo_clock_true(echo_t), .echo_clock_comp(echo_c), .pin_state(pins), .pin_drive(drive),
    .extest_active(extest));
  tap_tester i_tap_tester (.clk_sys, .tck, .tms, .tdi, .tdo);
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic echo_pass(input logic tie, input logic low);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      #1 out_tie = tie;
      in_ph = k[1];
      out_ph = k[0];
      repeat (6) @(posedge clk_sys);
      #1 check({echo_t, echo_c}, low ? 2'h0 : (tie ? {k[1], !k[1]} : {k[0], !k[0]}));
    end
    out_tie = 1'b0;
  endtask : echo_pass
  task automatic t_bypass();
    logic [127:0] q;
    i_tap_tester.load_ir(tap_pkg::INSN_BYPASS);
    i_tap_tester.move(8'h01, 3);
    repeat (4) @(posedge clk_sys);
    #1 check(128'(tdo_oe_n), 128'h0);
    i_tap_tester.scan(8, 128'hb5, q);
    check(q, 128'h6a);
    check(128'(tdo_oe_n), 128'h1);
    // reserved code must behave as bypass
    i_tap_tester.load_ir(3'h3);
    i_tap_tester.dr(8, 128'hb5, q);
    check(q, 128'h6a);
    $display("bypass test done");
  endtask : t_bypass
  task automatic t_sample();
    logic [127:0] q;
    logic [127:0] din;
    din = 128'h1c_3a5f_0f0f_3c3c_c3c3_5a5a_a5a5;
    i_tap_tester.load_ir(tap_pkg::INSN_SAMPLE);
    i_tap_tester.dr(tap_pkg::BSR_LEN, din, q);
    check(q, 128'(pins));
    check(128'(drive), din);
    $display("sample test done");
  endtask : t_sample
  task automatic t_tms_reset();
    logic [127:0] q;
    i_tap_tester.move(8'h01, 3);
    i_tap_tester.move(8'h1f, 6);
    i_tap_tester.dr(32, '0, q);
    check(q, 128'(tap_pkg::ID_VALUE));
    $display("mode select reset test done");
  endtask : t_tms_reset
  task automatic t_echo();
    echo_pass(1'b0, 1'b0);
    echo_pass(1'b1, 1'b0);
    i_tap_tester.load_ir(tap_pkg::INSN_EXTEST);
    check(128'(extest), 128'h1);
    echo_pass(1'b0, 1'b1);
    i_tap_tester.load_ir(tap_pkg::INSN_SAMPLE_Z);
    check(128'(extest), 128'h0);
    echo_pass(1'b0, 1'b1);
    i_tap_tester.move(8'h1f, 6);
    echo_pass(1'b0, 1'b0);
    $display("echo clock test done");
  endtask : t_echo
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    // controller wakes in test-logic-reset; the tester's paths start from idle
    #1 i_tap_tester.move(8'h00, 1);
    t_bypass();
    t_sample();
    t_tms_reset();
    t_echo();
    end_of_test();
  end
  initial begin
    #300000;
    n_errors++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
